// *** rtl/clblr_pkg.sv ***
// constants for the cursor layer blend and lookup table register bank
package clblr_pkg;
	localparam int          DATA_W         = 32;
	localparam int          COMP_W         = 8;
	localparam int          NUM_COMP       = 3;
	localparam int          LUT_DEPTH      = 256;
	localparam int          LUT_IDX_W      = 8;
	localparam int          LUT_IDX_LSB    = 2;
	localparam int          LUT_PAGE_LSB   = 10;

	// byte addresses of the word registers
	localparam logic [31:0] ADDR_ROW_PITCH = 32'hf803_837c;
	localparam logic [31:0] ADDR_DEF_COLOR = 32'hf803_8384;
	localparam logic [31:0] ADDR_KEY_REF   = 32'hf803_8388;
	localparam logic [31:0] ADDR_KEY_MASK  = 32'hf803_838c;
	localparam logic [31:0] ADDR_BLEND_CFG = 32'hf803_8390;
	localparam logic [31:0] ADDR_LUT_CTRL  = 32'hf803_8370;
	localparam logic [31:0] ADDR_BASE_LUT  = 32'hf803_8400;
	localparam logic [31:0] ADDR_OVR1_LUT  = 32'hf803_8800;
	localparam logic [31:0] ADDR_HEO_LUT   = 32'hf803_9000;

	// writable bit masks; all other bits read as zero
	localparam logic [31:0] MASK_FULL      = 32'hffff_ffff;
	localparam logic [31:0] MASK_RGB       = 32'h00ff_ffff;
	localparam logic [31:0] MASK_BLEND_CFG = 32'h00ff_07ff;
	localparam logic [31:0] MASK_LUT_CTRL  = 32'h0000_0301;
	localparam logic [31:0] RESET_VAL      = 32'h0000_0000;

	// blend configuration bits
	localparam int          BIT_CHROMA_EN  = 0;
	localparam int          BIT_NEGATE     = 1;
	localparam int          BIT_ADD_OPND   = 2;
	localparam int          BIT_USE_REPEAT = 3;
	localparam int          BIT_ALPHA_CMPL = 4;
	localparam int          BIT_GLOBAL_A   = 5;
	localparam int          BIT_LOCAL_A    = 6;
	localparam int          BIT_OVR_SRC    = 7;
	localparam int          BIT_DMA_EN     = 8;
	localparam int          BIT_LSB_FILL   = 9;
	localparam int          BIT_DST_KEY    = 10;
	localparam int          GA_LSB         = 16;

	// colour and lookup control fields
	localparam int          BLUE_LSB       = 0;
	localparam int          ALPHA_LSB      = 24;
	localparam int          LUT_EN_BIT     = 0;
	localparam int          LUT_DEPTH_LSB  = 8;
	localparam int          LUT_DEPTH_W    = 2;
	localparam logic [1:0]  DEPTH_1BPP     = 2'h0;
	localparam logic [1:0]  DEPTH_2BPP     = 2'h1;
	localparam logic [1:0]  DEPTH_4BPP     = 2'h2;
	localparam logic [7:0]  IDX_MASK_1     = 8'h01;
	localparam logic [7:0]  IDX_MASK_2     = 8'h03;
	localparam logic [7:0]  IDX_MASK_4     = 8'h0f;
	localparam logic [7:0]  IDX_MASK_8     = 8'hff;
	localparam logic [7:0]  ALPHA_OPAQUE   = 8'hff;
	localparam logic [7:0]  COMP_ZERO      = 8'h00;

	// lookup table selection and AHB transfer and response codes
	localparam logic [1:0]  LAYER_BASE     = 2'h0;
	localparam logic [1:0]  LAYER_OVR1     = 2'h1;
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
	localparam logic [1:0]  HRESP_OKAY     = 2'h0;
endpackage

// *** rtl/clblr_regs.sv ***
// cursor layer register bank with lookup tables and blend datapath
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
module clblr_regs
	import clblr_pkg::*;
(
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [clblr_pkg::DATA_W-1:0] hwdata,
	input  wire logic                        hready,
	output logic      [clblr_pkg::DATA_W-1:0] hrdata,
	output logic                             hreadyout,
	output logic                             hresp,
	input  wire logic                        row_start,
	input  wire logic [31:0]                 row_base_addr,
	input  wire logic                        row_advance,
	output logic      [31:0]                 fetch_addr,
	input  wire logic                        px_valid,
	input  wire logic [23:0]                 px_raw_rgb,
	input  wire logic [3:0]                  px_depth,
	input  wire logic [7:0]                  px_alpha,
	input  wire logic [23:0]                 dst_rgb,
	output logic      [23:0]                 blend_rgb,
	output logic                             key_hit,
	output logic                             blend_valid,
	input  wire logic                        lut_req,
	input  wire logic [1:0]                  lut_layer,
	input  wire logic [7:0]                  lut_raw_index,
	output logic      [31:0]                 lut_color,
	output logic                             lut_valid
);
	import clblr_pkg::*;

	logic [31:0] row_pitch_r, def_color_r, key_ref_r, key_mask_r, blend_cfg_r, lut_ctrl_r;
	logic [31:0] base_lut [LUT_DEPTH];
	logic [31:0] ovr1_lut [LUT_DEPTH];
	logic [31:0] heo_lut  [LUT_DEPTH];
	logic        wr_pend_r;
	logic [31:0] wr_addr_r;
	logic [31:0] it_r;
	logic        a_phase;
	logic        a_write;

	function automatic logic [31:0] reg_mask(input logic [31:0] a);
		logic [31:0] m;
		m = 32'h0000_0000;
		if (a == ADDR_ROW_PITCH)
			m = MASK_FULL;
		else if (a == ADDR_DEF_COLOR || a == ADDR_KEY_REF || a == ADDR_KEY_MASK)
			m = MASK_RGB;
		else if (a == ADDR_BLEND_CFG)
			m = MASK_BLEND_CFG;
		else if (a == ADDR_LUT_CTRL)
			m = MASK_LUT_CTRL;
		else if (a[31:LUT_PAGE_LSB] == ADDR_BASE_LUT[31:LUT_PAGE_LSB])
			m = MASK_RGB;
		else if (a[31:LUT_PAGE_LSB] == ADDR_OVR1_LUT[31:LUT_PAGE_LSB] ||
			a[31:LUT_PAGE_LSB] == ADDR_HEO_LUT[31:LUT_PAGE_LSB])
			m = MASK_FULL;
		return m;
	endfunction

	assign a_phase = hsel && hready && htrans == HTRANS_NONSEQ;
	assign a_write = a_phase && hwrite;

	// zero wait states; the slave stalls only in reset and up to the first edge after it, and never errors
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY[0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= RESET_VAL;
		end else begin
			wr_pend_r <= a_write;
			wr_addr_r <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			row_pitch_r <= RESET_VAL;
			def_color_r <= RESET_VAL;
			key_ref_r   <= RESET_VAL;
			key_mask_r  <= RESET_VAL;
			blend_cfg_r <= RESET_VAL;
			lut_ctrl_r  <= RESET_VAL;
		end else if (wr_pend_r) begin
			case (wr_addr_r)
				ADDR_ROW_PITCH: row_pitch_r <= hwdata & MASK_FULL;
				ADDR_DEF_COLOR: def_color_r <= hwdata & MASK_RGB;
				ADDR_KEY_REF:   key_ref_r   <= hwdata & MASK_RGB;
				ADDR_KEY_MASK:  key_mask_r  <= hwdata & MASK_RGB;
				ADDR_BLEND_CFG: blend_cfg_r <= hwdata & MASK_BLEND_CFG;
				ADDR_LUT_CTRL:  lut_ctrl_r  <= hwdata & MASK_LUT_CTRL;
				default: ;
			endcase
		end
	end

	// table storage is plain memory with no reset
	always_ff @(posedge hclk) begin
		if (wr_pend_r) begin
			if (wr_addr_r[31:LUT_PAGE_LSB] == ADDR_BASE_LUT[31:LUT_PAGE_LSB])
				base_lut[wr_addr_r[LUT_IDX_LSB +: LUT_IDX_W]] <= hwdata & MASK_RGB;
			if (wr_addr_r[31:LUT_PAGE_LSB] == ADDR_OVR1_LUT[31:LUT_PAGE_LSB])
				ovr1_lut[wr_addr_r[LUT_IDX_LSB +: LUT_IDX_W]] <= hwdata;
			if (wr_addr_r[31:LUT_PAGE_LSB] == ADDR_HEO_LUT[31:LUT_PAGE_LSB])
				heo_lut[wr_addr_r[LUT_IDX_LSB +: LUT_IDX_W]] <= hwdata;
		end
	end

	// read data sampled in the address phase; a write still in its data
	// phase to the same word is forwarded so back-to-back reads see it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= RESET_VAL;
		end else if (a_phase && !hwrite) begin
			if (wr_pend_r && wr_addr_r == haddr)
				hrdata <= hwdata & reg_mask(haddr);
			else if (haddr == ADDR_ROW_PITCH)
				hrdata <= row_pitch_r;
			else if (haddr == ADDR_DEF_COLOR)
				hrdata <= def_color_r;
			else if (haddr == ADDR_KEY_REF)
				hrdata <= key_ref_r;
			else if (haddr == ADDR_KEY_MASK)
				hrdata <= key_mask_r;
			else if (haddr == ADDR_BLEND_CFG)
				hrdata <= blend_cfg_r;
			else if (haddr == ADDR_LUT_CTRL)
				hrdata <= lut_ctrl_r;
			else if (haddr[31:LUT_PAGE_LSB] == ADDR_BASE_LUT[31:LUT_PAGE_LSB])
				hrdata <= base_lut[haddr[LUT_IDX_LSB +: LUT_IDX_W]];
			else if (haddr[31:LUT_PAGE_LSB] == ADDR_OVR1_LUT[31:LUT_PAGE_LSB])
				hrdata <= ovr1_lut[haddr[LUT_IDX_LSB +: LUT_IDX_W]];
			else if (haddr[31:LUT_PAGE_LSB] == ADDR_HEO_LUT[31:LUT_PAGE_LSB])
				hrdata <= heo_lut[haddr[LUT_IDX_LSB +: LUT_IDX_W]];
			else
				hrdata <= RESET_VAL;
		end
	end

	// row address stepping for the cursor fetch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			fetch_addr <= RESET_VAL;
		else if (row_start)
			fetch_addr <= row_base_addr;
		else if (row_advance)
			fetch_addr <= fetch_addr + row_pitch_r;
	end

	// lookup translation
	logic [7:0] lut_idx;
	logic [1:0] lut_depth_sel;
	assign lut_depth_sel = lut_ctrl_r[LUT_DEPTH_LSB +: LUT_DEPTH_W];

	always_comb begin
		case (lut_depth_sel)
			DEPTH_1BPP: lut_idx = lut_raw_index & IDX_MASK_1;
			DEPTH_2BPP: lut_idx = lut_raw_index & IDX_MASK_2;
			DEPTH_4BPP: lut_idx = lut_raw_index & IDX_MASK_4;
			default:    lut_idx = lut_raw_index & IDX_MASK_8;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lut_color <= RESET_VAL;
			lut_valid <= 1'b0;
		end else begin
			lut_valid <= lut_req && lut_ctrl_r[LUT_EN_BIT];
			if (lut_req && lut_ctrl_r[LUT_EN_BIT]) begin
				if (lut_layer == LAYER_BASE)
					lut_color <= base_lut[lut_idx];
				else if (lut_layer == LAYER_OVR1)
					lut_color <= ovr1_lut[lut_idx];
				else
					lut_color <= heo_lut[lut_idx];
			end
		end
	end

	// blender controls
	logic       dma_en, ovr_sel, key_en, dst_key, rev_a, ga_en, la_en, rep_en, inv_en, it_en, opnd_en;
	logic [7:0] glob_a, alpha, alpha_m;
	logic [15:0] ga_la;
	assign key_en  = blend_cfg_r[BIT_CHROMA_EN];
	assign inv_en  = blend_cfg_r[BIT_NEGATE];
	assign opnd_en = blend_cfg_r[BIT_ADD_OPND];
	assign it_en   = blend_cfg_r[BIT_USE_REPEAT];
	assign rev_a   = blend_cfg_r[BIT_ALPHA_CMPL];
	assign ga_en   = blend_cfg_r[BIT_GLOBAL_A];
	assign la_en   = blend_cfg_r[BIT_LOCAL_A];
	assign ovr_sel = blend_cfg_r[BIT_OVR_SRC];
	assign dma_en  = blend_cfg_r[BIT_DMA_EN];
	assign rep_en  = blend_cfg_r[BIT_LSB_FILL];
	assign dst_key = blend_cfg_r[BIT_DST_KEY];
	assign glob_a  = blend_cfg_r[GA_LSB +: COMP_W];
	assign ga_la   = glob_a * px_alpha;

	always_comb begin
		if (ga_en && la_en)
			alpha = ga_la[15:8];
		else if (ga_en)
			alpha = glob_a;
		else if (la_en)
			alpha = px_alpha;
		else
			alpha = ALPHA_OPAQUE;
		alpha_m = rev_a ? ~alpha : alpha;
	end

	logic [NUM_COMP-1:0] comp_match;
	logic [23:0]         mixed;

	for (genvar c = 0; c < NUM_COMP; c++) begin : g_comp
		localparam int LSB = BLUE_LSB + c * COMP_W;
		logic [7:0]  raw, shifted, fill, expd, ovr_px, dst_px, diff, opnd, key_px;
		logic [15:0] mix;
		logic [15:0] dmul;
		logic [9:0]  sum;

		// narrow components arrive right-aligned; shift up to eight bits
		always_comb begin
			raw     = px_raw_rgb[LSB +: COMP_W];
			shifted = raw << (4'(COMP_W) - px_depth);
			fill    = rep_en ? {COMP_W{shifted[COMP_W-1]}} : COMP_ZERO;
			expd    = shifted | (fill & ~(IDX_MASK_8 << (4'(COMP_W) - px_depth)));
			if (px_depth >= 4'(COMP_W))
				expd = raw;
		end

		// fallback colour whenever the channel or its overlay path is off
		assign ovr_px = (dma_en && ovr_sel) ? expd : def_color_r[LSB +: COMP_W];
		assign dst_px = dst_rgb[LSB +: COMP_W];
		assign key_px = dst_key ? dst_px : ovr_px;
		assign comp_match[c] = ((key_px ^ key_ref_r[LSB +: COMP_W]) & key_mask_r[LSB +: COMP_W]) == COMP_ZERO;
		assign diff   = it_en ? it_r[LSB +: COMP_W] : COMP_ZERO;
		assign opnd   = opnd_en ? it_r[LSB +: COMP_W] : COMP_ZERO;
		assign mix    = ovr_px * {8'h00, alpha_m} + ovr_px + dst_px * {8'h00, ~alpha_m};
		assign dmul   = diff * alpha_m;
		// saturate rather than wrap so a bright overlay cannot go dark
		assign sum    = {2'b00, mix[15:8]} + {2'b00, dmul[15:8]} + {2'b00, opnd};
		assign mixed[LSB +: COMP_W] = (sum > 10'(ALPHA_OPAQUE)) ? ALPHA_OPAQUE : sum[7:0];
	end

	logic hit;
	assign hit = key_en && (&comp_match);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blend_rgb   <= RESET_VAL[23:0];
			key_hit     <= 1'b0;
			blend_valid <= 1'b0;
			it_r        <= RESET_VAL;
		end else begin
			blend_valid <= px_valid;
			if (px_valid) begin
				key_hit <= hit;
				it_r    <= {8'h00, inv_en ? ~mixed : mixed};
				if (hit && !dst_key)
					blend_rgb <= dst_rgb;
				else if (!hit && dst_key && key_en)
					blend_rgb <= dst_rgb;
				else
					blend_rgb <= mixed;
			end
		end
	end

	sequence s_cfg_write;
		a_write && haddr == ADDR_BLEND_CFG ##1 1'b1;
	endsequence

	a_cfg_write_back: assert property (@(posedge hclk) disable iff (!hresetn)
		s_cfg_write |=> blend_cfg_r == ($past(hwdata) & MASK_BLEND_CFG))
		else $error("blend config did not take written value");
	a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		(blend_cfg_r & ~MASK_BLEND_CFG) == RESET_VAL && (def_color_r & ~MASK_RGB) == RESET_VAL)
		else $error("reserved bits not zero");
	a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(hresetn) |-> hreadyout && !hresp)
		else $error("slave stalled or errored");
	a_pitch_step: assert property (@(posedge hclk) disable iff (!hresetn)
		row_advance && !row_start |=> fetch_addr == $past(fetch_addr) + $past(row_pitch_r))
		else $error("fetch address not stepped by pitch");
	a_fallback_color: assert property (@(posedge hclk) disable iff (!hresetn)
		px_valid && !(dma_en && ovr_sel) && !key_en && !it_en && !opnd_en && !ga_en && !la_en && !rev_a
		|=> blend_rgb == $past(def_color_r[23:0]))
		else $error("fallback colour not shown");
	a_key_off: assert property (@(posedge hclk) disable iff (!hresetn)
		px_valid && !key_en |=> !key_hit)
		else $error("key hit while matching disabled");
	a_key_mask_none: assert property (@(posedge hclk) disable iff (!hresetn)
		px_valid && key_en && key_mask_r[23:0] == RESET_VAL[23:0] |=> key_hit)
		else $error("empty compare mask did not match");
	a_lut_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		lut_req && !lut_ctrl_r[LUT_EN_BIT] |=> !lut_valid && lut_color == $past(lut_color))
		else $error("lookup ran while disabled");
	a_base_no_alpha: assert property (@(posedge hclk) disable iff (!hresetn)
		lut_req && lut_ctrl_r[LUT_EN_BIT] && lut_layer == LAYER_BASE |=> lut_color[31:ALPHA_LSB] == COMP_ZERO)
		else $error("base table returned alpha");

	sequence s_color_write;
		a_write && haddr == ADDR_DEF_COLOR ##1 1'b1;
	endsequence
	a_color_write_back: assert property (@(posedge hclk) disable iff (!hresetn)
		s_color_write |=> def_color_r == ($past(hwdata) & MASK_RGB))
		else $error("default colour did not take written value");
	a_cfg_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
		a_phase && !hwrite && haddr == ADDR_BLEND_CFG && !(wr_pend_r && wr_addr_r == haddr)
		|=> hrdata == $past(blend_cfg_r))
		else $error("blend config read back wrong");
	a_row_load: assert property (@(posedge hclk) disable iff (!hresetn)
		row_start |=> fetch_addr == $past(row_base_addr))
		else $error("row start did not load base address");
	a_src_key_hit: assert property (@(posedge hclk) disable iff (!hresetn)
		px_valid && key_en && !dst_key && dma_en && ovr_sel && px_depth >= 4'(COMP_W) &&
		((px_raw_rgb ^ key_ref_r[23:0]) & key_mask_r[23:0]) == RESET_VAL[23:0]
		|=> key_hit && blend_rgb == $past(dst_rgb))
		else $error("source key match not replaced by destination");
	a_src_key_miss: assert property (@(posedge hclk) disable iff (!hresetn)
		px_valid && key_en && !dst_key && dma_en && ovr_sel && px_depth >= 4'(COMP_W) &&
		((px_raw_rgb ^ key_ref_r[23:0]) & key_mask_r[23:0]) != RESET_VAL[23:0] |=> !key_hit)
		else $error("source key hit on differing pixel");
	a_dst_key_hit: assert property (@(posedge hclk) disable iff (!hresetn)
		px_valid && key_en && dst_key &&
		((dst_rgb ^ key_ref_r[23:0]) & key_mask_r[23:0]) == RESET_VAL[23:0] |=> key_hit)
		else $error("destination key match missed");
	a_dst_key_miss: assert property (@(posedge hclk) disable iff (!hresetn)
		px_valid && key_en && dst_key && ((dst_rgb ^ key_ref_r[23:0]) & key_mask_r[23:0]) != RESET_VAL[23:0]
		|=> !key_hit && blend_rgb == $past(dst_rgb))
		else $error("destination key miss did not show destination");
	a_use_repeated_color_store: assert property (@(posedge hclk) disable iff (!hresetn)
		px_valid && !key_en |=> it_r[23:0] == ($past(inv_en) ? ~blend_rgb : blend_rgb))
		else $error("iterated colour not stored");
	a_blend_through: assert property (@(posedge hclk) disable iff (!hresetn)
		px_valid && !key_en && !it_en && !opnd_en && !ga_en && !la_en && !rev_a && dma_en && ovr_sel &&
		px_depth >= 4'(COMP_W) |=> blend_rgb == $past(px_raw_rgb))
		else $error("opaque channel pixel not passed through");
	a_operand_add: assert property (@(posedge hclk) disable iff (!hresetn)
		px_valid && !key_en && opnd_en && !it_en && !ga_en && !la_en && !rev_a && dma_en && ovr_sel &&
		px_depth >= 4'(COMP_W) && {1'b0, px_raw_rgb[7:0]} + {1'b0, it_r[7:0]} <= {1'b0, ALPHA_OPAQUE}
		|=> blend_rgb[7:0] == $past(px_raw_rgb[7:0] + it_r[7:0]))
		else $error("iterated operand not added");
	a_alpha_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		px_valid && ga_en && !la_en && glob_a == COMP_ZERO && !rev_a && !it_en && !opnd_en && !key_en &&
		dst_rgb == RESET_VAL[23:0] |=> blend_rgb == RESET_VAL[23:0])
		else $error("zero global alpha still showed overlay");
	a_lut_answer: assert property (@(posedge hclk) disable iff (!hresetn)
		lut_req && lut_ctrl_r[LUT_EN_BIT] |=> lut_valid)
		else $error("enabled lookup gave no answer");
	a_lut_one_bit: assert property (@(posedge hclk) disable iff (!hresetn)
		lut_req && lut_ctrl_r[LUT_EN_BIT] && lut_layer == LAYER_OVR1 && lut_depth_sel == DEPTH_1BPP
		|=> lut_color == $past(ovr1_lut[lut_raw_index & IDX_MASK_1]))
		else $error("one bit index not masked");
	a_expand_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		px_valid && !key_en && !rep_en && !it_en && !opnd_en && !ga_en && !la_en && !rev_a && dma_en &&
		ovr_sel && px_depth < 4'(COMP_W)
		|=> blend_rgb[7:0] == $past(px_raw_rgb[7:0] << (4'(COMP_W) - px_depth)))
		else $error("narrow component not zero filled");
endmodule // clblr_regs

// *** sim/test_clblr_regs.sv ***
// self-checking bench for the cursor layer register bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module test_clblr_regs;
	import clblr_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic        row_start, row_advance, px_valid, lut_req;
	logic        key_hit, blend_valid, lut_valid;
	logic [1:0]  htrans, lut_layer;
	logic [2:0]  hsize;
	logic [3:0]  px_depth;
	logic [7:0]  px_alpha, lut_raw_index;
	logic [23:0] px_raw_rgb, dst_rgb, blend_rgb;
	logic [31:0] haddr, hwdata, hrdata, row_base_addr, fetch_addr, lut_color;
	int          n_mismatch;
	int          n_checks;
	// first six words have reset values; lookup entries are left unreset
	logic [31:0] reg_addr [9] = '{ADDR_ROW_PITCH, ADDR_DEF_COLOR, ADDR_KEY_REF, ADDR_KEY_MASK, ADDR_BLEND_CFG,
		ADDR_LUT_CTRL, ADDR_BASE_LUT + 32'h0000_03fc, ADDR_OVR1_LUT + 32'h0000_03fc, ADDR_HEO_LUT + 32'h0000_03fc};
	logic [31:0] reg_mask [9] = '{MASK_FULL, MASK_RGB, MASK_RGB, MASK_RGB, MASK_BLEND_CFG,
		MASK_LUT_CTRL, MASK_RGB, MASK_FULL, MASK_FULL};

	clblr_regs dut_u (
		.hclk          (hclk),
		.hresetn       (hresetn),
		.hsel          (hsel),
		.haddr         (haddr),
		.htrans        (htrans),
		.hwrite        (hwrite),
		.hsize         (hsize),
		.hwdata        (hwdata),
		.hready        (hreadyout),
		.hrdata        (hrdata),
		.hreadyout     (hreadyout),
		.hresp         (hresp),
		.row_start     (row_start),
		.row_base_addr (row_base_addr),
		.row_advance   (row_advance),
		.fetch_addr    (fetch_addr),
		.px_valid      (px_valid),
		.px_raw_rgb    (px_raw_rgb),
		.px_depth      (px_depth),
		.px_alpha      (px_alpha),
		.dst_rgb       (dst_rgb),
		.blend_rgb     (blend_rgb),
		.key_hit       (key_hit),
		.blend_valid   (blend_valid),
		.lut_req       (lut_req),
		.lut_layer     (lut_layer),
		.lut_raw_index (lut_raw_index),
		.lut_color     (lut_color),
		.lut_valid     (lut_valid)
	);

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	task automatic print_verdict;
		if (n_mismatch == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// entered and left just after a rising edge; waits on hready, never a fixed count
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdat);
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rdat = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0000_0000, x);
		`CHK("register", exp, x)
		`CHK("hresp", 1'b0, hresp)
		`CHK("hreadyout", 1'b1, hreadyout)
	endtask

	task automatic pix(input logic [31:0] cfg, input logic [31:0] msk, input logic [23:0] raw, input logic [3:0] dep,
		input logic [7:0] al, input logic [23:0] dst, input logic [23:0] exp, input logic hit);
		wr(ADDR_BLEND_CFG, cfg);
		wr(ADDR_KEY_MASK, msk);
		px_valid <= 1'b1;
		px_raw_rgb <= raw;
		px_depth <= dep;
		px_alpha <= al;
		dst_rgb <= dst;
		@(posedge hclk);
		px_valid <= 1'b0;
		#1;
		`CHK("blend_valid", 1'b1, blend_valid)
		`CHK("blend_rgb", exp, blend_rgb)
		`CHK("key_hit", hit, key_hit)
		@(posedge hclk);
	endtask

	task automatic lut(input logic [1:0] lay, input logic [7:0] idx, input logic v, input logic [31:0] exp);
		lut_req <= 1'b1;
		lut_layer <= lay;
		lut_raw_index <= idx;
		@(posedge hclk);
		lut_req <= 1'b0;
		#1;
		`CHK("lut_valid", v, lut_valid)
		`CHK("lut_color", exp, lut_color)
		@(posedge hclk);
	endtask

	initial begin
		logic [7:0] idx;
		n_mismatch = 0;
		n_checks = 0;
		hresetn = 1'b0;
		hsel = 1'b1;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		row_start = 1'b0;
		row_advance = 1'b0;
		row_base_addr = 32'h0000_0000;
		px_valid = 1'b0;
		px_raw_rgb = 24'h000000;
		px_depth = 4'h8;
		px_alpha = 8'h00;
		dst_rgb = 24'h000000;
		lut_req = 1'b0;
		lut_layer = 2'h0;
		lut_raw_index = 8'h00;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 6; i++) rchk(reg_addr[i], RESET_VAL);
		for (int i = 0; i < 9; i++) begin
			wr(reg_addr[i], MASK_FULL);
			rchk(reg_addr[i], reg_mask[i]);
		end
		// gap word between two registers must stay empty
		wr(32'hf803_8380, MASK_FULL);
		rchk(32'hf803_8380, 32'h0000_0000);
		wr(ADDR_ROW_PITCH, 32'h0000_0100);
		row_base_addr <= 32'h0000_1000;
		row_start <= 1'b1;
		row_advance <= 1'b1;
		@(posedge hclk);
		row_start <= 1'b0;
		#1;
		`CHK("fetch_addr", 32'h0000_1000, fetch_addr)
		@(posedge hclk);
		#1;
		`CHK("fetch_addr", 32'h0000_1100, fetch_addr)
		@(posedge hclk);
		row_advance <= 1'b0;
		#1;
		`CHK("fetch_addr", 32'h0000_1200, fetch_addr)
		@(posedge hclk);
		wr(ADDR_LUT_CTRL, 32'h0000_0000);
		for (int d = 0; d < 4; d++) begin
			idx = 8'((1 << (1 << d)) - 1);
			wr(ADDR_OVR1_LUT + {22'h0, idx, 2'h0}, 32'hc0de_0000 | 32'(d));
		end
		wr(ADDR_HEO_LUT + 32'h0000_0040, 32'h5a5a_5a5a);
		lut(LAYER_OVR1, 8'hff, 1'b0, 32'h0000_0000);
		for (int d = 0; d < 4; d++) begin
			wr(ADDR_LUT_CTRL, 32'h0000_0001 | (32'(d) << 8));
			lut(LAYER_OVR1, 8'hff, 1'b1, 32'hc0de_0000 | 32'(d));
		end
		lut(LAYER_BASE, 8'hff, 1'b1, 32'h00ff_ffff);
		lut(2'h2, 8'h10, 1'b1, 32'h5a5a_5a5a);
		lut(2'h3, 8'h10, 1'b1, 32'h5a5a_5a5a);
		wr(ADDR_DEF_COLOR, 32'h0033_6699);
		wr(ADDR_KEY_REF, 32'h0012_3456);
		pix(32'h0000_0000, 32'h0, 24'hffffff, 4'h8, 8'h00, 24'h000000, 24'h336699, 1'b0);
		pix(32'h0000_0100, 32'h0, 24'hffffff, 4'h8, 8'h00, 24'h000000, 24'h336699, 1'b0);
		pix(32'h0000_0080, 32'h0, 24'hffffff, 4'h8, 8'h00, 24'h000000, 24'h336699, 1'b0);
		pix(32'h0000_0180, 32'h0, 24'ha5c3e1, 4'h8, 8'h00, 24'h000000, 24'ha5c3e1, 1'b0);
		pix(32'h0000_0180, 32'h0, 24'h101010, 4'h5, 8'h00, 24'h000000, 24'h808080, 1'b0);
		pix(32'h0000_0380, 32'h0, 24'h101010, 4'h5, 8'h00, 24'h000000, 24'h878787, 1'b0);
		pix(32'h007f_01a0, 32'h0, 24'hffffff, 4'h8, 8'h00, 24'h000000, 24'h7f7f7f, 1'b0);
		pix(32'h0000_01c0, 32'h0, 24'hffffff, 4'h8, 8'h7f, 24'h000000, 24'h7f7f7f, 1'b0);
		pix(32'h00ff_01e0, 32'h0, 24'hffffff, 4'h8, 8'h80, 24'h000000, 24'h7f7f7f, 1'b0);
		pix(32'h0000_01a0, 32'h0, 24'hffffff, 4'h8, 8'h00, 24'h000000, 24'h000000, 1'b0);
		pix(32'h0000_01b0, 32'h0, 24'hffffff, 4'h8, 8'h00, 24'h000000, 24'hffffff, 1'b0);
		pix(32'h0000_0181, 32'h00ff_ffff, 24'h123456, 4'h8, 8'h00, 24'habcdef, 24'habcdef, 1'b1);
		pix(32'h0000_0181, 32'h00ff_ffff, 24'h123457, 4'h8, 8'h00, 24'habcdef, 24'h123457, 1'b0);
		pix(32'h0000_0180, 32'h00ff_ffff, 24'h123456, 4'h8, 8'h00, 24'habcdef, 24'h123456, 1'b0);
		pix(32'h0000_0181, 32'h00f0_f0f0, 24'h1f3f5f, 4'h8, 8'h00, 24'habcdef, 24'habcdef, 1'b1);
		pix(32'h0000_0581, 32'h0, 24'h000000, 4'h8, 8'h00, 24'habcdef, 24'h000000, 1'b1);
		pix(32'h0000_0581, 32'h00ff_ffff, 24'h000000, 4'h8, 8'h00, 24'habcdef, 24'habcdef, 1'b0);
		// iterated colour carries over from one pixel to the next
		pix(32'h0000_0182, 32'h0, 24'h101010, 4'h8, 8'h00, 24'h000000, 24'h101010, 1'b0);
		pix(32'h0000_0184, 32'h0, 24'h050505, 4'h8, 8'h00, 24'h000000, 24'hf4f4f4, 1'b0);
		pix(32'h0000_0180, 32'h0, 24'h101010, 4'h8, 8'h00, 24'h000000, 24'h101010, 1'b0);
		pix(32'h0000_0188, 32'h0, 24'h050505, 4'h8, 8'h00, 24'h000000, 24'h141414, 1'b0);
		print_verdict;
	end

	// a few hundred cycles are expected; cut a hang well beyond that
	initial begin
		#100000;
		n_mismatch++;
		print_verdict;
	end
endmodule // test_clblr_regs
